/* verilog/tmwave_top.sv */
/*
 * 8-bit timer with two compare channels, mode select and compare
 * output control, reached over APB.
 * Assumes pclk at 125 MHz, tick inputs synchronous to pclk.
 */
//
// Behaviour
// - Count only on tick; async tick when selected
// - Nonzero mode A lets channel A own pin
// - Drive pin only when direction bit set
// - Non-PWM A: off, toggle, clear, set
// - PWM A mode 1 toggles if top bit
// - Phase PWM A mode 1 off without top bit
// - Fast PWM A: clear/set on match, inverse TOP
// - Phase PWM A: up/down match opposite actions
// - Compare equals TOP: ignore match, act TOP
// - Nonzero mode B lets channel B own pin
// - Non-PWM B: off, toggle, clear, set
// - Fast PWM B: mode 1 reserved, else like A
// - Phase PWM B: mode 1 reserved, else like A
// - Bits 3:2 read zero; fields reset zero
// - Mode is top bit plus two low bits
// - Modes 4 and 6 reserved, undefined
// - Modes 0,2 immediate compare, flag at MAX
// - PWM buffers at TOP; flag per mode
// - Fast PWM counts up, wraps at TOP
// - Phase PWM up, hold TOP, down
`timescale 1ns/1ns
`default_nettype none

module tmwave_top
	import tmwave_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    timer_tick_enable,
	input  wire logic                    async_tick_enable,
	output tmwave_pkg::tmwave_pin_type   cmp_out_pin_a,
	output tmwave_pkg::tmwave_pin_type   cmp_out_pin_b,
	output logic [7:0]                   count_value
);
	import tmwave_pkg::*;

	logic [7:0] waveform_ctrl_a;
	logic [7:0] waveform_ctrl_b;
	logic [7:0] cmp_value_a;
	logic [7:0] cmp_value_b;
	logic [7:0] buf_cmp_a;
	logic [7:0] buf_cmp_b;
	logic [2:0] status;
	logic [2:0] pin_ctrl;
	logic       count_down;
	logic [1:0] wave;

	logic [2:0] wave_mode_field;
	logic [1:0] out_mode_chan_a;
	logic [1:0] out_mode_chan_b;
	logic       tick;
	logic       is_fast;
	logic       is_pc;
	logic       is_pwm;
	logic [7:0] top_val;
	logic       at_top;
	logic [7:0] next_count;
	logic       next_down;
	logic       ovf_ev;
	logic [1:0] match_ev;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;

	// Mode decode
	assign wave_mode_field = {waveform_ctrl_b[POS_WM_TOP],
		waveform_ctrl_a[1:0]};
	assign out_mode_chan_a = waveform_ctrl_a[POS_OM_A_HI:POS_OM_A_LO];
	assign out_mode_chan_b = waveform_ctrl_a[POS_OM_B_HI:POS_OM_B_LO];
	// Pick the tick source; only one steps the counter per cycle
	assign tick = pin_ctrl[POS_ASYNC] ? async_tick_enable
		: timer_tick_enable;
	// Reserved modes 4 and 6 fall through as clear on match, TOP from compare A
	assign is_fast = (wave_mode_field[1:0] == 2'h3);
	assign is_pc   = (wave_mode_field[1:0] == 2'h1);
	assign is_pwm  = is_fast | is_pc;
	assign top_val = (wave_mode_field == WM_CTC || wave_mode_field[2])
		? buf_cmp_a : CNT_MAX;
	assign at_top  = (count_value == top_val);

	// Next count and slope
	always_comb begin
		next_count = count_value;
		next_down  = count_down;
		ovf_ev     = 1'b0;
		if (is_pc) begin
			if (!count_down && at_top) begin
				next_down = 1'b1;
			end else if (count_down && count_value == CNT_BOTTOM) begin
				next_down  = 1'b0;
				next_count = count_value + 8'h01;
			end else if (count_down) begin
				next_count = count_value - 8'h01;
				ovf_ev     = (count_value == 8'h01);
			end else begin
				next_count = count_value + 8'h01;
			end
		end else begin
			next_down = 1'b0;
			// Fast and CLEAR_ON_MATCH_MODE wrap at TOP; normal rolls over MAX
			if (at_top && wave_mode_field != WM_NORMAL) begin
				next_count = CNT_BOTTOM;
			end else begin
				next_count = count_value + 8'h01;
			end
			if (wave_mode_field == WM_FAST_CMP) begin
				ovf_ev = at_top;
			end else begin
				ovf_ev = (count_value == CNT_MAX);
			end
		end
	end

	// Counter; a bus write wins over counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= 8'h00;
			count_down  <= 1'b0;
		end else if (wr_en && paddr == ADDR_COUNT) begin
			count_value <= pwdata[7:0];
		end else if (tick) begin
			count_value <= next_count;
			count_down  <= next_down;
		end
	end

	// Active compare values: immediate or loaded at TOP
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_cmp_a <= 8'h00;
			buf_cmp_b <= 8'h00;
		end else if (!is_pwm) begin
			buf_cmp_a <= cmp_value_a;
			buf_cmp_b <= cmp_value_b;
		end else if (tick && at_top) begin
			buf_cmp_a <= cmp_value_a;
			buf_cmp_b <= cmp_value_b;
		end
	end

	// Per-channel match and waveform
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic [7:0] cmpv;
			logic [1:0] om;
			logic       hit;
			logic       ign;
			logic       next_w;
			assign cmpv = (ch == 0) ? buf_cmp_a : buf_cmp_b;
			assign om   = (ch == 0) ? out_mode_chan_a : out_mode_chan_b;
			assign hit  = tick && (count_value == cmpv);
			assign match_ev[ch] = hit;
			// Match at TOP ignored in PWM when high bit set
			assign ign = is_pwm && om[1] && (cmpv == top_val);
			always_comb begin
				next_w = wave[ch];
				if (!is_pwm) begin
					if (hit) begin
						unique case (om)
							OM_OFF:    next_w = wave[ch];
							OM_TOGGLE: next_w = ~wave[ch];
							OM_CLEAR:  next_w = 1'b0;
							OM_SET:    next_w = 1'b1;
						endcase
					end
				end else if (om == OM_TOGGLE) begin
					// Channel B has no PWM toggle; reserved code idles
					if (ch == 0 && wave_mode_field[2] && hit) begin
						next_w = ~wave[ch];
					end
				end else if (om[1] && is_fast) begin
					if (tick && at_top) begin
						next_w = ~om[0];
					end else if (hit && !ign) begin
						next_w = om[0];
					end
				end else if (om[1]) begin
					if (ign && tick && at_top) begin
						next_w = ~om[0];
					end else if (hit && !ign) begin
						next_w = count_down ? ~om[0] : om[0];
					end
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wave[ch] <= 1'b0;
				end else begin
					wave[ch] <= next_w;
				end
			end
		end
	endgenerate

	// Pin drive: owned when mode set, enabled by direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_out_pin_a <= '0;
			cmp_out_pin_b <= '0;
		end else begin
			// PWM toggle on A needs the top bit to connect
			cmp_out_pin_a.oe <= (out_mode_chan_a != OM_OFF)
				&& !(is_pwm && out_mode_chan_a == OM_TOGGLE
				&& !wave_mode_field[2])
				&& pin_ctrl[POS_DIR_A];
			cmp_out_pin_a.val <= wave[0];
			cmp_out_pin_b.oe <= (out_mode_chan_b != OM_OFF)
				&& pin_ctrl[POS_DIR_B];
			cmp_out_pin_b.val <= wave[1];
		end
	end

	// APB decode; zero wait state
	assign addr_ok = (paddr == ADDR_CTRL_A) || (paddr == ADDR_CTRL_B)
		|| (paddr == ADDR_COUNT) || (paddr == ADDR_CMP_A)
		|| (paddr == ADDR_CMP_B) || (paddr == ADDR_STATUS)
		|| (paddr == ADDR_PINCTRL);
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && !penable && !pwrite;

	// Control and compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_ctrl_a <= RST_CTRL;
			waveform_ctrl_b <= RST_CTRL;
			cmp_value_a     <= 8'h00;
			cmp_value_b     <= 8'h00;
			pin_ctrl        <= 3'h0;
		end else if (wr_en) begin
			unique case (paddr)
				ADDR_CTRL_A: waveform_ctrl_a <= pwdata[7:0] & MASK_CTRL_A;
				ADDR_CTRL_B: waveform_ctrl_b <= pwdata[7:0] & MASK_CTRL_B;
				ADDR_CMP_A:  cmp_value_a <= pwdata[7:0];
				ADDR_CMP_B:  cmp_value_b <= pwdata[7:0];
				ADDR_PINCTRL: pin_ctrl <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Sticky flags; a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if ((i == POS_OVF && tick && ovf_ev)
					|| (i == POS_MATCH_A && match_ev[0])
					|| (i == POS_MATCH_B && match_ev[1])) begin
					status[i] <= 1'b1;
				end else if (wr_en && paddr == ADDR_STATUS && pwdata[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	end

	// Read data registered in setup so access phase answers at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en) begin
				unique case (paddr)
					ADDR_CTRL_A:  prdata <= {24'h0, waveform_ctrl_a};
					ADDR_CTRL_B:  prdata <= {24'h0, waveform_ctrl_b};
					ADDR_COUNT:   prdata <= {24'h0, count_value};
					ADDR_CMP_A:   prdata <= {24'h0, cmp_value_a};
					ADDR_CMP_B:   prdata <= {24'h0, cmp_value_b};
					ADDR_STATUS:  prdata <= {29'h0, status};
					ADDR_PINCTRL: prdata <= {29'h0, pin_ctrl};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Assertions
	property p_tick_gate;
		@(posedge pclk) disable iff (!presetn)
		(!tick && !(wr_en && paddr == ADDR_COUNT)) |=> $stable(count_value);
	endproperty
	a_tick_gate: assert property (p_tick_gate)
		else $error("count moved without tick");
	property p_dir_gate;
		@(posedge pclk) disable iff (!presetn)
		!pin_ctrl[POS_DIR_A] |=> !cmp_out_pin_a.oe;
	endproperty
	a_dir_gate: assert property (p_dir_gate)
		else $error("pin A driven with input direction");
	property p_off_a;
		@(posedge pclk) disable iff (!presetn)
		(out_mode_chan_a == OM_OFF) |=> !cmp_out_pin_a.oe;
	endproperty
	a_off_a: assert property (p_off_a)
		else $error("pin A owned while disconnected");
	property p_ctc_toggle;
		@(posedge pclk) disable iff (!presetn)
		(!is_pwm && out_mode_chan_a == OM_TOGGLE && match_ev[0])
			|=> (wave[0] != $past(wave[0]));
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle)
		else $error("toggle on match missing");
	property p_fast_top;
		@(posedge pclk) disable iff (!presetn)
		(is_fast && out_mode_chan_b == OM_CLEAR && tick && at_top)
			|=> wave[1];
	endproperty
	a_fast_top: assert property (p_fast_top)
		else $error("fast PWM B not set at TOP");
	property p_fast_wrap;
		@(posedge pclk) disable iff (!presetn)
		(is_fast && tick && at_top && !wr_en) |=> (count_value == 8'h00);
	endproperty
	a_fast_wrap: assert property (p_fast_wrap)
		else $error("fast PWM did not wrap");
	property p_pc_hold;
		@(posedge pclk) disable iff (!presetn)
		(is_pc && tick && at_top && !count_down && !wr_en)
			|=> (count_down && $stable(count_value));
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("phase PWM did not hold TOP");
	// Only reads carry fresh data; writes leave the last word standing
	property p_rsvd_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && psel && penable && !pwrite && paddr == ADDR_CTRL_A)
			|-> (prdata[3:2] == 2'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");
	property p_match;
		@(posedge pclk) disable iff (!presetn)
		(tick && count_value == buf_cmp_b) |=> status[POS_MATCH_B];
	endproperty
	a_match: assert property (p_match)
		else $error("match flag B not set");

	c_fast: cover property (@(posedge pclk) disable iff (!presetn)
		is_fast && tick && at_top);
	c_pc_turn: cover property (@(posedge pclk) disable iff (!presetn)
		is_pc && count_down && count_value == 8'h00 && tick);
	c_ovf: cover property (@(posedge pclk) disable iff (!presetn)
		tick && ovf_ev);

endmodule // tmwave_top

`default_nettype wire

/* verilog/tmwave_pkg.sv */
/*
 * Package for the 8-bit timer waveform block: register map, field
 * positions, reset values, mode encodings and the pin carrier struct.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package tmwave_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
	localparam logic [7:0] ADDR_COUNT    = 8'h08;
	localparam logic [7:0] ADDR_CMP_A    = 8'h0C;
	localparam logic [7:0] ADDR_CMP_B    = 8'h10;
	localparam logic [7:0] ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ADDR_PINCTRL  = 8'h18;

	// Field positions in waveform_ctrl_a
	localparam int POS_OM_A_HI = 7;
	localparam int POS_OM_A_LO = 6;
	localparam int POS_OM_B_HI = 5;
	localparam int POS_OM_B_LO = 4;
	// Field position in waveform_ctrl_b
	localparam int POS_WM_TOP  = 3;
	// Writable bits of waveform_ctrl_a and waveform_ctrl_b
	localparam logic [7:0] MASK_CTRL_A = 8'hF3;
	localparam logic [7:0] MASK_CTRL_B = 8'h08;
	localparam logic [7:0] RST_CTRL    = 8'h00;

	// Status bits: overflow, match A, match B (write one to clear)
	localparam int POS_OVF   = 0;
	localparam int POS_MATCH_A = 1;
	localparam int POS_MATCH_B = 2;
	// Pin control: direction A, direction B, async clock select
	localparam int POS_DIR_A = 0;
	localparam int POS_DIR_B = 1;
	localparam int POS_ASYNC = 2;

	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// Waveform mode codes
	localparam logic [2:0] WM_NORMAL  = 3'h0;
	localparam logic [2:0] WM_PC_FF   = 3'h1;
	localparam logic [2:0] WM_CTC     = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PC_CMP  = 3'h5;
	localparam logic [2:0] WM_FAST_CMP = 3'h7;

	// Output mode codes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	// Pin carrier: value and output enable
	typedef struct packed {
		logic val;
		logic oe;
	} tmwave_pin_type;

endpackage : tmwave_pkg

/* dv/tmwave_top_tb.sv */
/*
 * Self-checking bench for the timer waveform block: APB register access,
 * tick gating, compare output modes in normal, fast and phase PWM.
 * Assumes the package and top module of the design are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module tmwave_top_tb;
	import tmwave_pkg::*;

	logic           pclk;
	logic           presetn;
	logic           psel;
	logic           penable;
	logic           pwrite;
	logic [7:0]     paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           tick;
	logic           atick;
	tmwave_pin_type pin_a;
	tmwave_pin_type pin_b;
	logic [7:0]     count_value;
	logic           look_r;
	logic           look_c;
	logic [7:0]     q_cnt[$];
	logic [7:0]     ec;
	logic [32:0]    q_rd[$];
	logic [7:0]     q_pin[$];
	logic [32:0]    got;
	logic [7:0]     ep;
	int             errors;
	int             n_tests;
	int             cyc;
	int             k;

	tmwave_top dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.timer_tick_enable (tick),
		.async_tick_enable (atick),
		.cmp_out_pin_a     (pin_a),
		.cmp_out_pin_b     (pin_b),
		.count_value       (count_value)
	);

	// Free-running bus clock, 8 ns period
	always #4 pclk = ~pclk;

	task give_verdict;
		$display("errors=%0d comparisons=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard; the full run needs under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			give_verdict;
		end
	end

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends once pready is sampled high; the hang guard stops a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	// Expected word noted before the read; monitor compares it
	task rd(input logic [7:0] a, input logic [32:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h00000000);
	endtask

	// Exactly n high tick cycles on the chosen input, then settle
	task ticks(input int n, input logic use_async);
		repeat (n) begin
			@(posedge pclk);
			tick <= !use_async;
			atick <= use_async;
		end
		@(posedge pclk);
		tick <= 1'b0;
		atick <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	// Pin check {oe_a, val_a, oe_b, val_b} under a mask
	task look(input logic [3:0] e, input logic [3:0] m);
		q_pin.push_back({m, e});
		@(posedge pclk);
		look_r <= 1'b1;
		@(posedge pclk);
		look_r <= 1'b0;
	endtask

	// Counter port check, noted before the look
	task look_cnt(input logic [7:0] e);
		q_cnt.push_back(e);
		@(posedge pclk);
		look_c <= 1'b1;
		@(posedge pclk);
		look_c <= 1'b0;
	endtask

	// Monitor: takes the oldest note whenever a result shows
	always @(posedge pclk) begin
		if (look_c === 1'b1) begin
			ec = q_cnt.pop_front();
			n_tests++;
			if (count_value !== ec) begin
				errors++;
				$display("Error at %0t: count port %h", $time, count_value);
			end
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			got = {pslverr, prdata};
			n_tests++;
			if (got !== q_rd.pop_front()) begin
				errors++;
				$display("Error at %0t: read data %h", $time, got);
			end
		end
		if (look_r === 1'b1) begin
			ep = q_pin.pop_front();
			n_tests++;
			if ((({pin_a.oe, pin_a.val, pin_b.oe, pin_b.val} ^ ep[3:0])
			    & ep[7:4]) !== 4'h0) begin
				errors++;
				$display("Error at %0t: pin state wrong", $time);
			end
		end
	end

	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, tick, atick, look_r, look_c} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		{errors, n_tests, cyc} = 0;
		k = $urandom(32'h984C);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values of every register, then an unmapped word
		for (int i = 0; i < 7; i++)
			rd(ADDR_CTRL_A + 8'(4 * i), 33'h0);
		rd(8'h1C, {1'b1, 32'h0});
		wr(ADDR_CTRL_A, 8'hFF);
		rd(ADDR_CTRL_A, {25'h0, MASK_CTRL_A});
		wr(ADDR_CTRL_B, 8'hFF);
		rd(ADDR_CTRL_B, {25'h0, MASK_CTRL_B});
		wr(ADDR_CTRL_A, RST_CTRL);
		wr(ADDR_CTRL_B, RST_CTRL);
		k = $urandom_range(255, 0);
		wr(ADDR_CMP_B, 8'(k));
		rd(ADDR_CMP_B, {25'h0, 8'(k)});
		// Tick gating: inactive source must not step the count
		ticks(10, 1'b1);
		rd(ADDR_COUNT, 33'h0);
		ticks(10, 1'b0);
		rd(ADDR_COUNT, 33'h0A);
		look_cnt(8'h0A);
		wr(ADDR_PINCTRL, 8'h07);
		ticks(7, 1'b0);
		ticks(7, 1'b1);
		rd(ADDR_COUNT, 33'h11);
		look_cnt(8'h11);
		wr(ADDR_PINCTRL, 8'h03);
		// Normal mode toggle on both channels, random run length
		wr(ADDR_CMP_A, 8'h05);
		wr(ADDR_CMP_B, 8'h05);
		wr(ADDR_CTRL_A, {OM_TOGGLE, OM_TOGGLE, 4'h0});
		wr(ADDR_COUNT, 8'h00);
		ticks($urandom_range(200, 6), 1'b0);
		look(4'hF, 4'hF);
		wr(ADDR_PINCTRL, 8'h00);
		look(4'h0, 4'hA);
		wr(ADDR_PINCTRL, 8'h03);
		// Set then clear on match, both channels
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CTRL_A, s ? {OM_CLEAR, OM_CLEAR, 4'h0}
			                  : {OM_SET, OM_SET, 4'h0});
			wr(ADDR_COUNT, 8'h00);
			ticks(10, 1'b0);
			look(s ? 4'hA : 4'hF, 4'hF);
		end
		wr(ADDR_CTRL_A, RST_CTRL);
		look(4'h0, 4'hA);
		// Overflow at MAX in normal mode, write one to clear
		wr(ADDR_STATUS, 8'h07);
		rd(ADDR_STATUS, 33'h0);
		wr(ADDR_COUNT, 8'hFC);
		ticks(5, 1'b0);
		rd(ADDR_STATUS, 33'h01);
		wr(ADDR_STATUS, 8'h07);
		// Fast PWM, TOP 0xFF: A set on match, B clear on match
		wr(ADDR_CTRL_A, {OM_SET, OM_CLEAR, 4'h3});
		wr(ADDR_COUNT, 8'h00);
		ticks(10, 1'b0);
		look(4'hE, 4'hF);
		ticks(250, 1'b0);
		look(4'hB, 4'hF);
		rd(ADDR_STATUS, 33'h07);
		wr(ADDR_CTRL_A, {OM_TOGGLE, 2'h0, 4'h3});
		look(4'h0, 4'h8);
		// Fast PWM, TOP from compare A, toggle with top bit set
		wr(ADDR_CTRL_A, RST_CTRL);
		wr(ADDR_CMP_A, 8'h14);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CTRL_B, 8'h08);
		wr(ADDR_CTRL_A, {OM_TOGGLE, 2'h0, 4'h3});
		ticks(21, 1'b0);
		rd(ADDR_COUNT, 33'h0);
		look_cnt(8'h00);
		look(4'hC, 4'hC);
		// Phase PWM, TOP 20: B set going up, cleared coming down
		wr(ADDR_CTRL_A, {2'h0, OM_SET, 4'h1});
		wr(ADDR_COUNT, 8'h00);
		ticks(8, 1'b0);
		look(4'h3, 4'hB);
		ticks(32, 1'b0);
		look(4'h2, 4'h3);
		// Phase PWM without top bit: toggle code leaves pin alone
		wr(ADDR_CTRL_B, RST_CTRL);
		wr(ADDR_CTRL_A, {OM_TOGGLE, 2'h0, 4'h1});
		look(4'h0, 4'h8);
		give_verdict;
	end

endmodule // tmwave_top_tb

`default_nettype wire
